// *** ctp_pkg.sv ***
// Constants, field layout and carrier types for the cascadable timer pair.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package ctp_pkg;

  localparam int unsigned AW = 12;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CNT_LO  = 10'h106;
  localparam logic [9:0] IDX_HOLD    = 10'h108;
  localparam logic [9:0] IDX_CNT_HI  = 10'h10a;
  localparam logic [9:0] IDX_PER_LO  = 10'h10c;
  localparam logic [9:0] IDX_PER_HI  = 10'h10e;
  localparam logic [9:0] IDX_CTL_LO  = 10'h110;
  localparam logic [9:0] IDX_CTL_HI  = 10'h112;
  localparam logic [9:0] IDX_IRQ_FLG = 10'h114;
  localparam logic [9:0] IDX_IRQ_EN  = 10'h116;

  localparam logic [15:0] PER_RST = 16'hffff;
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;

  // Control field positions
  localparam int unsigned BIT_ON   = 15;
  localparam int unsigned BIT_IDLE = 13;
  localparam int unsigned BIT_GATE = 6;
  localparam int unsigned BIT_PSC  = 4;
  localparam int unsigned BIT_JOIN = 3;
  localparam int unsigned BIT_CS   = 1;

  // Interrupt flag and enable positions
  localparam int unsigned IRQ_BIT_HI = 7;
  localparam int unsigned IRQ_BIT_LO = 6;

  // Prescaler terminal counts for 1, 8, 64, 256
  localparam logic [7:0] PSC_LAST_1   = 8'h00;
  localparam logic [7:0] PSC_LAST_8   = 8'h07;
  localparam logic [7:0] PSC_LAST_64  = 8'h3f;
  localparam logic [7:0] PSC_LAST_256 = 8'hff;

  typedef struct packed {
    logic       timer_on;
    logic       idle_stop_select;
    logic       gated_accum_enable;
    logic [1:0] prescale_select;
    logic       pair_join_bit;
    logic       clock_source_select;
  } ctp_ctl_t;

  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } ctp_tb_t;

  function automatic ctp_ctl_t ctp_decode(input logic [15:0] w);
    ctp_ctl_t c;
    c.timer_on            = w[BIT_ON];
    c.idle_stop_select    = w[BIT_IDLE];
    c.gated_accum_enable  = w[BIT_GATE];
    c.prescale_select     = w[BIT_PSC+1:BIT_PSC];
    c.pair_join_bit       = w[BIT_JOIN];
    c.clock_source_select = w[BIT_CS];
    return c;
  endfunction : ctp_decode

endpackage : ctp_pkg

// *** ctp_timer_pair.sv ***
// Pair of 16-bit timers, optionally cascaded into one 32-bit timer.
// Assumes pclk is the instruction-cycle clock and all pins are synchronous.
`timescale 1ns/1ps
`default_nettype none

module ctp_timer_pair #(
  parameter bit HAS_ADC_TRIG = 1'b1,
  parameter bit HAS_TIMEBASE = 1'b1,
  parameter bit HAS_PINS     = 1'b1
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ctp_pkg::AW-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    sleep_mode,
  input  wire logic                    idle_mode,
  input  wire logic                    ext_pin_lo,
  input  wire logic                    ext_pin_hi,
  output logic                         irq_lo,
  output logic                         irq_hi,
  output logic                         adc_trig,
  output ctp_pkg::ctp_tb_t             timebase
);
  import ctp_pkg::*;

  logic [15:0] cnt_lo_q, cnt_lo_d, cnt_hi_q, cnt_hi_d;
  logic [15:0] hold_q, hold_d, per_lo_q, per_lo_d, per_hi_q, per_hi_d;
  logic [15:0] ctl_lo_q, ctl_lo_d, ctl_hi_q, ctl_hi_d;
  logic [7:0]  psc_lo_q, psc_lo_d, psc_hi_q, psc_hi_d;
  logic [1:0]  flag_q, flag_d, ien_q, ien_d, pin_q, pin_d;
  logic        adc_q, adc_d;
  logic [31:0] rdata_q, rdata_d;

  ctp_ctl_t    cl, ch;
  logic        acc, wr_en, rd_en, mapped, join32;
  logic        act_l, act_h, pin_l, pin_h, src_l, src_h;
  logic        tick_l, tick_h, inc_l, inc_h, gfall;
  logic        match32, match_l, match_h;
  logic [31:0] cnt32, per32;

  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [9:0] idx);
    return a == {idx, 2'b00};
  endfunction : hit

  function automatic logic [7:0] psc_last(input logic [1:0] sel);
    unique case (sel)
      2'b00: return PSC_LAST_1;
      2'b01: return PSC_LAST_8;
      2'b10: return PSC_LAST_64;
      2'b11: return PSC_LAST_256;
    endcase
  endfunction : psc_last

  assign acc     = psel & penable;
  assign wr_en   = acc & pwrite;
  assign rd_en   = acc & ~pwrite;
  assign mapped  = hit(paddr, IDX_CNT_LO) | hit(paddr, IDX_HOLD)
                 | hit(paddr, IDX_CNT_HI) | hit(paddr, IDX_PER_LO)
                 | hit(paddr, IDX_PER_HI) | hit(paddr, IDX_CTL_LO)
                 | hit(paddr, IDX_CTL_HI) | hit(paddr, IDX_IRQ_FLG)
                 | hit(paddr, IDX_IRQ_EN);
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata  = rdata_q;

  always_comb begin
    cl     = ctp_decode(ctl_lo_q);
    ch     = ctp_decode({ctl_hi_q[15:4], 1'b0, ctl_hi_q[2:0]});
    join32 = cl.pair_join_bit;
    cnt32  = {cnt_hi_q, cnt_lo_q};
    per32  = {per_hi_q, per_lo_q};
    // Without pins the inputs read low, so pin modes just stall
    pin_l  = HAS_PINS & ext_pin_lo;
    pin_h  = HAS_PINS & ext_pin_hi;
    pin_d  = {pin_h, pin_l};
    act_l  = cl.timer_on & ~sleep_mode
           & ~(idle_mode & cl.idle_stop_select);
    act_h  = ch.timer_on & ~sleep_mode & ~join32
           & ~(idle_mode & ch.idle_stop_select);
    src_l  = cl.clock_source_select ? (pin_l & ~pin_q[0])
           : (cl.gated_accum_enable ? pin_l : 1'b1);
    src_h  = ch.clock_source_select ? (pin_h & ~pin_q[1])
           : (ch.gated_accum_enable ? pin_h : 1'b1);
    tick_l = act_l & src_l;
    tick_h = act_h & src_h;
    inc_l  = tick_l & (psc_lo_q == psc_last(cl.prescale_select));
    inc_h  = tick_h & (psc_hi_q == psc_last(ch.prescale_select));
    // Gate fall stops counting but leaves the count alone
    gfall  = cl.timer_on & ~sleep_mode & cl.gated_accum_enable
           & ~cl.clock_source_select & ~pin_l & pin_q[0];

    psc_lo_d = tick_l ? (inc_l ? 8'h00 : psc_lo_q + 8'h01) : psc_lo_q;
    psc_hi_d = tick_h ? (inc_h ? 8'h00 : psc_hi_q + 8'h01) : psc_hi_q;
    if (!cl.timer_on) psc_lo_d = 8'h00;
    if (!ch.timer_on || join32) psc_hi_d = 8'h00;

    cnt_lo_d = cnt_lo_q;
    cnt_hi_d = cnt_hi_q;
    match32  = 1'b0;
    match_l  = 1'b0;
    match_h  = 1'b0;
    if (join32) begin
      if (inc_l) begin
        match32 = (cnt32 == per32);
        {cnt_hi_d, cnt_lo_d} = match32 ? 32'h0 : cnt32 + 32'h1;
      end
    end else begin
      if (inc_l) begin
        match_l  = (cnt_lo_q == per_lo_q);
        cnt_lo_d = match_l ? CNT_RST : cnt_lo_q + 16'h0001;
      end
      if (inc_h) begin
        match_h  = (cnt_hi_q == per_hi_q);
        cnt_hi_d = match_h ? CNT_RST : cnt_hi_q + 16'h0001;
      end
    end

    hold_d   = hold_q;
    per_lo_d = per_lo_q;
    per_hi_d = per_hi_q;
    ctl_lo_d = ctl_lo_q;
    ctl_hi_d = ctl_hi_q;
    flag_d   = flag_q;
    ien_d    = ien_q;
    if (rd_en && hit(paddr, IDX_CNT_LO)) hold_d = cnt_hi_q;
    if (wr_en) begin
      if (hit(paddr, IDX_CNT_LO)) begin
        cnt_lo_d = pwdata[15:0];
        psc_lo_d = 8'h00;
        if (join32) cnt_hi_d = hold_q;
      end
      if (hit(paddr, IDX_CNT_HI)) begin
        cnt_hi_d = pwdata[15:0];
        psc_hi_d = 8'h00;
        if (join32) psc_lo_d = 8'h00;
      end
      if (hit(paddr, IDX_HOLD))   hold_d   = pwdata[15:0];
      if (hit(paddr, IDX_PER_LO)) per_lo_d = pwdata[15:0];
      if (hit(paddr, IDX_PER_HI)) per_hi_d = pwdata[15:0];
      if (hit(paddr, IDX_CTL_LO)) ctl_lo_d = pwdata[15:0];
      if (hit(paddr, IDX_CTL_HI)) ctl_hi_d = pwdata[15:0] & 16'hfff7;
      if (hit(paddr, IDX_IRQ_FLG))
        flag_d = {pwdata[IRQ_BIT_HI], pwdata[IRQ_BIT_LO]};
      if (hit(paddr, IDX_IRQ_EN))
        ien_d = {pwdata[IRQ_BIT_HI], pwdata[IRQ_BIT_LO]};
    end
    // Hardware set wins over a software clear in the same cycle
    if (match32 || (join32 && gfall) || match_h) flag_d[1] = 1'b1;
    if ((!join32 && gfall) || match_l) flag_d[0] = 1'b1;
    adc_d = HAS_ADC_TRIG & (match32 | match_h);

    rdata_d = rdata_q;
    if (psel && !penable) begin
      rdata_d = 32'h0;
      if (hit(paddr, IDX_CNT_LO))  rdata_d[15:0] = cnt_lo_q;
      if (hit(paddr, IDX_HOLD))    rdata_d[15:0] = hold_q;
      if (hit(paddr, IDX_CNT_HI))  rdata_d[15:0] = cnt_hi_q;
      if (hit(paddr, IDX_PER_LO))  rdata_d[15:0] = per_lo_q;
      if (hit(paddr, IDX_PER_HI))  rdata_d[15:0] = per_hi_q;
      if (hit(paddr, IDX_CTL_LO))  rdata_d[15:0] = ctl_lo_q;
      if (hit(paddr, IDX_CTL_HI))  rdata_d[15:0] = ctl_hi_q;
      if (hit(paddr, IDX_IRQ_FLG)) begin
        rdata_d[IRQ_BIT_HI] = flag_q[1];
        rdata_d[IRQ_BIT_LO] = flag_q[0];
      end
      if (hit(paddr, IDX_IRQ_EN)) begin
        rdata_d[IRQ_BIT_HI] = ien_q[1];
        rdata_d[IRQ_BIT_LO] = ien_q[0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_lo_q <= CNT_RST;
      cnt_hi_q <= CNT_RST;
      hold_q   <= CNT_RST;
      per_lo_q <= PER_RST;
      per_hi_q <= PER_RST;
      ctl_lo_q <= CTL_RST;
      ctl_hi_q <= CTL_RST;
      psc_lo_q <= 8'h00;
      psc_hi_q <= 8'h00;
      flag_q   <= 2'h0;
      ien_q    <= 2'h0;
      pin_q    <= 2'h0;
      adc_q    <= 1'b0;
      rdata_q  <= 32'h0;
    end else begin
      cnt_lo_q <= cnt_lo_d;
      cnt_hi_q <= cnt_hi_d;
      hold_q   <= hold_d;
      per_lo_q <= per_lo_d;
      per_hi_q <= per_hi_d;
      ctl_lo_q <= ctl_lo_d;
      ctl_hi_q <= ctl_hi_d;
      psc_lo_q <= psc_lo_d;
      psc_hi_q <= psc_hi_d;
      flag_q   <= flag_d;
      ien_q    <= ien_d;
      pin_q    <= pin_d;
      adc_q    <= adc_d;
      rdata_q  <= rdata_d;
    end
  end

  assign irq_hi   = flag_q[1] & ien_q[1];
  assign irq_lo   = flag_q[0] & ien_q[0];
  assign adc_trig = adc_q;
  assign timebase = HAS_TIMEBASE ? ctp_tb_t'({cnt_hi_q, cnt_lo_q})
                                 : ctp_tb_t'(32'h0);

  logic wr_cnt, wr_flg;
  assign wr_cnt = wr_en & (hit(paddr, IDX_CNT_LO) | hit(paddr, IDX_CNT_HI));
  assign wr_flg = wr_en & hit(paddr, IDX_IRQ_FLG);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_sleep_no_count: assert property (
    sleep_mode && !wr_cnt |=> $stable(cnt_lo_q) && $stable(cnt_hi_q))
    else $error("count moved during sleep");
  a_join_match_flag: assert property (
    join32 && inc_l && cnt32 == per32 |=> flag_q[1] && cnt32 == 32'h0)
    else $error("joined match did not flag and wrap");
  a_flag_sticky: assert property (
    flag_q[1] && !wr_flg |=> flag_q[1])
    else $error("upper flag cleared by hardware");
  a_irq_gating: assert property (
    wr_en && hit(paddr, IDX_IRQ_EN) && !pwdata[IRQ_BIT_HI] |=> !irq_hi)
    else $error("irq stayed up without enable");
  a_join_ignores_hi: assert property (
    join32 |=> psc_hi_q == 8'h00)
    else $error("upper prescaler ran while joined");
  a_no_adc_trig: assert property (
    !HAS_ADC_TRIG |-> !adc_trig)
    else $error("second instance raised converter trigger");
  a_hold_latch: assert property (
    rd_en && hit(paddr, IDX_CNT_LO) |=> hold_q == $past(cnt_hi_q))
    else $error("hold did not latch upper half");
  a_coherent_wr: assert property (
    wr_en && join32 && hit(paddr, IDX_CNT_LO)
    |=> cnt_hi_q == $past(hold_q) && psc_lo_q == 8'h00)
    else $error("coherent write failed");
  a_off_hold: assert property (
    !cl.timer_on && !join32 && !wr_cnt |=> $stable(cnt_lo_q))
    else $error("disabled timer advanced");
  a_match_16: assert property (
    !join32 && inc_l && cnt_lo_q == per_lo_q && !wr_cnt
    |=> cnt_lo_q == 16'h0 && flag_q[0])
    else $error("16-bit match failed");
  a_idle_stop: assert property (
    idle_mode && cl.idle_stop_select && !wr_cnt |=> $stable(cnt_lo_q))
    else $error("count moved during idle stop");
  // Upper half moves only by carry or match wrap when joined
  a_hi_carry_only: assert property (
    join32 && !wr_cnt && !inc_l |=> $stable(cnt_hi_q))
    else $error("upper half moved without carry");
  a_psc_wr_clear: assert property (
    wr_en && hit(paddr, IDX_CNT_LO) |=> psc_lo_q == 8'h00)
    else $error("count write left prescaler running");
  a_psc_off_clear: assert property (
    !cl.timer_on |=> psc_lo_q == 8'h00)
    else $error("prescaler kept value while off");
  a_gate_fall_flag: assert property (
    join32 && gfall |=> flag_q[1])
    else $error("joined gate fall did not flag");
  a_adc_source: assert property (
    adc_trig |-> $past(match32) || $past(match_h))
    else $error("converter trigger without match");

  c_join_match: cover property (join32 && match32);
  c_gate_fall: cover property (gfall ##1 flag_q[1]);
  c_psc_256: cover property (inc_l && cl.prescale_select == 2'b11);
  c_idle_stop: cover property (idle_mode && cl.idle_stop_select);
  c_coherent: cover property (wr_en && join32 && hit(paddr, IDX_CNT_LO));

endmodule : ctp_timer_pair

`default_nettype wire

// *** ctp_pin_model.sv ***
// Far-side model of the lower timer's external clock or gate pin.
// Assumes the pin idles low between bursts, as with a pull-down.
`timescale 1ns/1ps
`default_nettype none
module ctp_pin_model (
  input  wire logic pclk,
  output logic      pin
);
  initial pin = 1'b0;
  // High for hi cycles then low for lo cycles, n times; call after an edge
  task automatic burst(input int n, input int hi, input int lo);
    repeat (n) begin
      pin <= 1'b1;
      repeat (hi) @(posedge pclk);
      pin <= 1'b0;
      repeat (lo) @(posedge pclk);
    end
  endtask : burst
endmodule : ctp_pin_model
`default_nettype wire

// *** ctp_timer_pair_tb.sv ***
// Self-checking bench for the timer pair, both instances on one APB bus.
// Assumes an APB slave; the pin model drives the first pair's pins.
`timescale 1ns/1ps
`default_nettype none
module ctp_timer_pair_tb;
  import ctp_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, sleep_mode, use2;
  logic          idle_mode;
  logic [AW-1:0] paddr;
  logic [31:0]   pwdata, prdata, rdv, a;
  logic          pready, pslverr, perr, irq_lo, irq_hi, adc1, adc2, pin;
  ctp_tb_t       tb1, tb2;
  int            n_fail, cmp_count, n_adc1, n_adc2;

  ctp_timer_pair ctp_timer_pair_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_mode(sleep_mode), .idle_mode(idle_mode), .ext_pin_lo(pin),
    .ext_pin_hi(pin), .irq_lo(irq_lo), .irq_hi(irq_hi), .adc_trig(adc1),
    .timebase(tb1));
  // Second pair sees writes only while no pin mode is in use
  ctp_timer_pair #(.HAS_ADC_TRIG(1'b0), .HAS_TIMEBASE(1'b0),
    .HAS_PINS(1'b0)) ctp_timer_pair_2_i (.pclk(pclk), .presetn(presetn),
    .psel(psel & use2), .penable(penable & use2), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .sleep_mode(sleep_mode), .idle_mode(idle_mode), .ext_pin_lo(1'b0),
    .ext_pin_hi(1'b0), .irq_lo(), .irq_hi(), .adc_trig(adc2),
    .timebase(tb2));
  ctp_pin_model ctp_pin_model_i (.pclk(pclk), .pin(pin));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Opposite edge keeps pulse counting clear of the design's updates
  always @(negedge pclk) begin
    if (adc1 === 1'b1) n_adc1++;
    if (adc2 !== 1'b0) n_adc2++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic chkr(input logic [31:0] lo, input logic [31:0] hi);
    chk(32'(rdv >= lo && rdv <= hi), 32'h1);
  endtask : chkr
  task automatic apb(input logic w, input logic [9:0] i, input logic [15:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [9:0] i, input logic [15:0] d);
    apb(1'b1, i, d);
  endtask : wr
  task automatic rd(input logic [9:0] i);
    apb(1'b0, i, 16'h0000);
  endtask : rd

  task automatic s_reset;
    rd(IDX_PER_HI);
    chk(rdv, {16'h0000, PER_RST});
    rd(IDX_CTL_LO);
    chk(rdv, 32'h0);
    rd(IDX_HOLD);
    chk(rdv, 32'h0);
    rd(10'h3ff);
    chk({31'h0, perr}, 32'h1);
    chk(rdv, 32'h0);
  endtask : s_reset

  task automatic s_ctl;
    wr(IDX_CNT_LO, 16'h1234);
    wr(IDX_CTL_LO, 16'h207a);
    rd(IDX_CTL_LO);
    chk(rdv, 32'h207a);
    wr(IDX_CTL_HI, 16'h207a);
    rd(IDX_CTL_HI);
    chk(rdv, 32'h2072);
    rd(IDX_CNT_LO);
    chk(rdv, 32'h1234);
    wr(IDX_CTL_LO, 16'h0000);
    wr(IDX_CTL_HI, 16'h0000);
  endtask : s_ctl

  task automatic s_split;
    wr(IDX_PER_LO, 16'h0004);
    wr(IDX_CNT_LO, 16'h0000);
    wr(IDX_CTL_LO, 16'h8000);
    repeat (4) begin
      rd(IDX_CNT_LO);
      chkr(32'h0, 32'h4);
    end
    rd(IDX_IRQ_FLG);
    chk(rdv, 32'h40);
    chk({31'h0, irq_lo}, 32'h0);
    wr(IDX_IRQ_EN, 16'h0040);
    chk({31'h0, irq_lo}, 32'h1);
    sleep_mode <= 1'b1;
    @(posedge pclk);
    rd(IDX_CNT_LO);
    a = rdv;
    repeat (10) @(posedge pclk);
    rd(IDX_CNT_LO);
    chk(rdv, a);
    sleep_mode <= 1'b0;
    idle_mode <= 1'b1;
    wr(IDX_PER_LO, 16'hffff);
    wr(IDX_CNT_LO, 16'h0000);
    repeat (10) @(posedge pclk);
    rd(IDX_CNT_LO);
    chkr(32'd8, 32'd16);
    wr(IDX_CTL_LO, 16'ha000);
    rd(IDX_CNT_LO);
    a = rdv;
    repeat (10) @(posedge pclk);
    rd(IDX_CNT_LO);
    chk(rdv, a);
    idle_mode <= 1'b0;
    wr(IDX_CTL_LO, 16'h0000);
    wr(IDX_PER_LO, 16'hffff);
    wr(IDX_IRQ_FLG, 16'h0000);
    wr(IDX_IRQ_EN, 16'h0000);
  endtask : s_split

  task automatic s_psc;
    int r[4] = '{1, 8, 64, 256};
    for (int p = 0; p < 4; p++) begin
      wr(IDX_CTL_LO, 16'h8000 | 16'(p << 4));
      wr(IDX_CNT_LO, 16'h0000);
      repeat (r[p] * 8) @(posedge pclk);
      rd(IDX_CNT_LO);
      chkr(32'd7, 32'd11);
    end
    wr(IDX_CTL_LO, 16'h0000);
  endtask : s_psc

  task automatic s_join;
    wr(IDX_PER_HI, 16'h0003);
    wr(IDX_PER_LO, 16'h0000);
    // Upper control set to run slowly; joined mode must ignore it
    wr(IDX_CTL_HI, 16'h8030);
    wr(IDX_CTL_LO, 16'h8008);
    wr(IDX_HOLD, 16'h0001);
    wr(IDX_CNT_LO, 16'hfff0);
    repeat (30) @(posedge pclk);
    rd(IDX_CNT_LO);
    chkr(32'h8, 32'h18);
    rd(IDX_HOLD);
    chk(rdv, 32'h2);
    wr(IDX_CTL_LO, 16'h0008);
    wr(IDX_PER_HI, 16'h0000);
    wr(IDX_PER_LO, 16'h0005);
    wr(IDX_HOLD, 16'h0000);
    wr(IDX_CNT_LO, 16'h0000);
    wr(IDX_IRQ_FLG, 16'h0000);
    wr(IDX_CTL_LO, 16'h8008);
    repeat (20) @(posedge pclk);
    rd(IDX_CNT_LO);
    chkr(32'h0, 32'h5);
    rd(IDX_IRQ_FLG);
    chk(rdv, 32'h80);
    chk({31'h0, irq_hi}, 32'h0);
    wr(IDX_IRQ_EN, 16'h0080);
    chk({31'h0, irq_hi}, 32'h1);
    wr(IDX_CTL_LO, 16'h0008);
    repeat (5) @(posedge pclk);
    rd(IDX_IRQ_FLG);
    chk(rdv, 32'h80);
    wr(IDX_IRQ_FLG, 16'h0000);
    rd(IDX_IRQ_FLG);
    chk(rdv, 32'h0);
    wr(IDX_IRQ_EN, 16'h0000);
    wr(IDX_CTL_HI, 16'h0000);
  endtask : s_join

  task automatic s_pins;
    use2 <= 1'b0;
    wr(IDX_PER_HI, 16'hffff);
    wr(IDX_PER_LO, 16'hffff);
    wr(IDX_CNT_LO, 16'h0000);
    wr(IDX_CTL_LO, 16'h8048);
    ctp_pin_model_i.burst(1, 20, 4);
    rd(IDX_CNT_LO);
    a = rdv;
    chkr(32'd17, 32'd22);
    repeat (10) @(posedge pclk);
    rd(IDX_CNT_LO);
    chk(rdv, a);
    rd(IDX_IRQ_FLG);
    chk(rdv, 32'h80);
    wr(IDX_CTL_LO, 16'h8002);
    wr(IDX_CNT_LO, 16'h0000);
    ctp_pin_model_i.burst(10, 3, 4);
    ctp_pin_model_i.burst(5, 1, 1);
    rd(IDX_CNT_LO);
    chk(rdv, 32'd15);
    chk(tb1, 32'd15);
    wr(IDX_CTL_LO, 16'h0000);
    use2 <= 1'b1;
  endtask : s_pins

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  initial begin
    #(8 * 40000);
    n_fail++;
    print_verdict;
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, sleep_mode, idle_mode} = 5'h00;
    use2 = 1'b1;
    paddr = '0;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_reset;
    s_ctl;
    s_split;
    s_psc;
    s_join;
    s_pins;
    chk(32'(n_adc1 > 0), 32'h1);
    chk(32'(n_adc2), 32'h0);
    chk(tb2, 32'h0);
    print_verdict;
  end
endmodule : ctp_timer_pair_tb
`default_nettype wire
